// ### ebbpr_pad_ctrl.sv
`timescale 1ns/10ps
module ebbpr_pad_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input ebbpr_pkg::ebbpr_regs_t regs,
	output ebbpr_pkg::ebbpr_pad_t pad_ctrl
);

	// ----------------------------------------------------------------
	// per-pin decode
	// ----------------------------------------------------------------
	ebbpr_pkg::ebbpr_pad_t next_pad_ctrl;

	always_comb begin
		logic [1:0] code;
		code = 2'b00;
		next_pad_ctrl = '0;
		for (int i = 0; i < ebbpr_pkg::PORT_WIDTH; i++) begin // R12
			code = {regs.port_drive_config_high[i], regs.port_drive_config_low[i]};
			next_pad_ctrl.oe_n[i] = 1'b1;
			next_pad_ctrl.out[i] = 1'b0;
			next_pad_ctrl.pull_up_en[i] = 1'b0;
			next_pad_ctrl.pull_down_en[i] = 1'b0;
			if (!regs.port_pin_direction[i]) begin // R5 R11
				unique case (ebbpr_pkg::ebbpr_out_mode_t'(code)) // R9
					ebbpr_pkg::OUT_HIGH_Z: begin
						next_pad_ctrl.oe_n[i] = 1'b1; // R15
					end
					ebbpr_pkg::OUT_PCH_OPEN_DRAIN: begin
						next_pad_ctrl.out[i] = 1'b1;
						next_pad_ctrl.oe_n[i] = ~regs.port_pin_data[i]; // R15
					end
					ebbpr_pkg::OUT_NCH_OPEN_DRAIN: begin
						next_pad_ctrl.out[i] = 1'b0;
						next_pad_ctrl.oe_n[i] = regs.port_pin_data[i]; // R15
					end
					ebbpr_pkg::OUT_CMOS: begin
						next_pad_ctrl.out[i] = regs.port_pin_data[i]; // R1 R4
						next_pad_ctrl.oe_n[i] = 1'b0;
					end
				endcase
			end else begin
				unique case (ebbpr_pkg::ebbpr_in_mode_t'(code)) // R10
					ebbpr_pkg::IN_PULL_DOWN: next_pad_ctrl.pull_down_en[i] = 1'b1;
					ebbpr_pkg::IN_PULL_UP: next_pad_ctrl.pull_up_en[i] = 1'b1;
					ebbpr_pkg::IN_HIGH_Z, ebbpr_pkg::IN_HIGH_Z_ALT: begin
						next_pad_ctrl.pull_up_en[i] = 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// registered pad controls: reset leaves every driver off
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_ctrl.out <= '0;
			pad_ctrl.oe_n <= '1; // R8
			pad_ctrl.pull_up_en <= '0;
			pad_ctrl.pull_down_en <= '0;
		end else begin
			pad_ctrl <= next_pad_ctrl;
		end
	end

endmodule : ebbpr_pad_ctrl

// ### ebbpr_pin_model.sv
`timescale 1ns/10ps
module ebbpr_pin_model (
	input wire logic pclk,
	input ebbpr_pkg::ebbpr_pad_t pad_ctrl,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pad_in
);
	// ----
	// board pins
	// ----
	// an undriven, unpulled pin toggles so no settled value can pass for a real level
	logic [7:0] last = 8'h00;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad_ctrl.oe_n[i]) pad_in[i] = pad_ctrl.out[i];
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (pad_ctrl.pull_up_en[i]) pad_in[i] = 1'b1;
			else if (pad_ctrl.pull_down_en[i]) pad_in[i] = 1'b0;
			else pad_in[i] = ~last[i];
		end
	end
	always_ff @(posedge pclk) begin
		last <= pad_in;
	end
endmodule : ebbpr_pin_model

// ### ebbpr_pkg.sv
package ebbpr_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int PORT_WIDTH = 8;
	localparam int ADDR_WIDTH = 20;
	localparam int DATA_WIDTH = 32;
	localparam int STRB_WIDTH = 4;

	// ----------------------------------------------------------------
	// register indices and byte addresses (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_PIN_DATA = 16'hF230;
	localparam logic [15:0] IDX_PIN_DIRECTION = 16'hF231;
	localparam logic [15:0] IDX_DRIVE_CONFIG_LOW = 16'hF232;
	localparam logic [15:0] IDX_DRIVE_CONFIG_HIGH = 16'hF233;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PIN_DATA = {2'h0, IDX_PIN_DATA, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_PIN_DIRECTION = {2'h0, IDX_PIN_DIRECTION, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_DRIVE_CONFIG_LOW = {2'h0, IDX_DRIVE_CONFIG_LOW, 2'h0};
	localparam logic [ADDR_WIDTH-1:0] ADDR_DRIVE_CONFIG_HIGH = {2'h0, IDX_DRIVE_CONFIG_HIGH, 2'h0};

	// ----------------------------------------------------------------
	// reset values and byte-lane patterns
	// ----------------------------------------------------------------
	localparam logic [PORT_WIDTH-1:0] RESET_PORT_REG = 8'h00;
	localparam logic [DATA_WIDTH-1:0] RESET_RDATA = 32'h0000_0000;
	localparam logic [STRB_WIDTH-1:0] STRB_BYTE = 4'h1;
	localparam logic [STRB_WIDTH-1:0] STRB_HALF = 4'h3;
	localparam int HIGH_LANE = 1;

	// ----------------------------------------------------------------
	// drive codes, {config_high, config_low} of one pin
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OUT_HIGH_Z = 2'b00,
		OUT_PCH_OPEN_DRAIN = 2'b01,
		OUT_NCH_OPEN_DRAIN = 2'b10,
		OUT_CMOS = 2'b11
	} ebbpr_out_mode_t;

	typedef enum logic [1:0] {
		IN_HIGH_Z = 2'b00,
		IN_PULL_DOWN = 2'b01,
		IN_PULL_UP = 2'b10,
		IN_HIGH_Z_ALT = 2'b11
	} ebbpr_in_mode_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_PIN_DATA = 3'b001,
		SEL_PIN_DIRECTION = 3'b010,
		SEL_DRIVE_CONFIG_LOW = 3'b011,
		SEL_DRIVE_CONFIG_HIGH = 3'b100
	} ebbpr_sel_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_ACCESS = 1'b1
	} ebbpr_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PORT_WIDTH-1:0] port_pin_data;
		logic [PORT_WIDTH-1:0] port_pin_direction;
		logic [PORT_WIDTH-1:0] port_drive_config_low;
		logic [PORT_WIDTH-1:0] port_drive_config_high;
	} ebbpr_regs_t;

	typedef struct packed {
		logic [PORT_WIDTH-1:0] out;
		logic [PORT_WIDTH-1:0] oe_n;
		logic [PORT_WIDTH-1:0] pull_up_en;
		logic [PORT_WIDTH-1:0] pull_down_en;
	} ebbpr_pad_t;

endpackage : ebbpr_pkg

// ### ebbpr_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: output pins drive the stored data bit.
// R2: data reads give the written value for output pins.
// R3: data reads give the sampled pin level for input pins.
// R4: bit n is pin n; 0 is low, 1 is high.
// R5: direction 0 is output, 1 is input; resets to output.
// R6: data, direction, config low, config high at consecutive indices.
// R7: config low takes byte or halfword; others byte only.
// R8: all four registers reset to zero: high-z outputs, data low.
// R9: output codes 00 off, 01 p-open-drain, 10 n-open-drain, 11 cmos.
// R10: input codes 00 plain, 01 pull-down, 10 pull-up, 11 plain.
// R11: config code meaning follows the pin's current direction.
// R12: every control bit acts on its own pin only.
// R13: software puts analog-used pins in high-z output mode first.
// R14: halfword at config low: low byte to low, high byte to high.
// R15: open drain drives only active level; high-z output drives nothing.
module ebbpr_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ebbpr_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [ebbpr_pkg::DATA_WIDTH-1:0] pwdata,
	input wire logic [ebbpr_pkg::STRB_WIDTH-1:0] pstrb,
	output logic [ebbpr_pkg::DATA_WIDTH-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ebbpr_pkg::PORT_WIDTH-1:0] pad_in,
	output ebbpr_pkg::ebbpr_pad_t pad_ctrl
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic ebbpr_pkg::ebbpr_sel_t decode_sel(
		input logic [ebbpr_pkg::ADDR_WIDTH-1:0] addr
	);
		ebbpr_pkg::ebbpr_sel_t sel;
		sel = ebbpr_pkg::SEL_NONE;
		if (addr == ebbpr_pkg::ADDR_PIN_DATA) begin // R6
			sel = ebbpr_pkg::SEL_PIN_DATA;
		end else if (addr == ebbpr_pkg::ADDR_PIN_DIRECTION) begin
			sel = ebbpr_pkg::SEL_PIN_DIRECTION;
		end else if (addr == ebbpr_pkg::ADDR_DRIVE_CONFIG_LOW) begin
			sel = ebbpr_pkg::SEL_DRIVE_CONFIG_LOW;
		end else if (addr == ebbpr_pkg::ADDR_DRIVE_CONFIG_HIGH) begin
			sel = ebbpr_pkg::SEL_DRIVE_CONFIG_HIGH;
		end
		return sel;
	endfunction : decode_sel

	// only config low accepts the halfword; every other write must be lane 0 alone
	function automatic logic lanes_ok(
		input ebbpr_pkg::ebbpr_sel_t sel,
		input logic [ebbpr_pkg::STRB_WIDTH-1:0] strb
	);
		logic ok;
		ok = (strb == ebbpr_pkg::STRB_BYTE); // R7
		if (sel == ebbpr_pkg::SEL_DRIVE_CONFIG_LOW && strb == ebbpr_pkg::STRB_HALF) begin
			ok = 1'b1; // R7
		end
		return ok;
	endfunction : lanes_ok

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	logic [ebbpr_pkg::PORT_WIDTH-1:0] pad_meta;
	logic [ebbpr_pkg::PORT_WIDTH-1:0] pad_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_meta <= '0;
		end else begin
			pad_meta <= pad_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_sync <= '0;
		end else begin
			pad_sync <= pad_meta;
		end
	end

	// ----------------------------------------------------------------
	// apb phase tracking
	// ----------------------------------------------------------------
	ebbpr_pkg::ebbpr_state_t state;
	ebbpr_pkg::ebbpr_state_t next_state;
	ebbpr_pkg::ebbpr_sel_t acc_sel;
	ebbpr_pkg::ebbpr_sel_t next_sel;
	logic setup_phase;
	logic wr_fire;
	logic next_err;
	logic [ebbpr_pkg::DATA_WIDTH-1:0] next_rdata;
	ebbpr_pkg::ebbpr_regs_t regs;

	assign setup_phase = (state == ebbpr_pkg::ST_IDLE) && psel && !penable;
	assign next_sel = decode_sel(paddr);
	// the answer is always taken in the first access cycle, so the write lands there
	assign wr_fire = (state == ebbpr_pkg::ST_ACCESS) && psel && penable && pwrite && !pslverr;

	always_comb begin
		next_state = state;
		unique case (state)
			ebbpr_pkg::ST_IDLE: begin
				if (setup_phase) begin
					next_state = ebbpr_pkg::ST_ACCESS;
				end
			end
			ebbpr_pkg::ST_ACCESS: begin
				next_state = ebbpr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ebbpr_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_sel <= ebbpr_pkg::SEL_NONE;
		end else if (setup_phase) begin
			acc_sel <= next_sel;
		end
	end

	// ----------------------------------------------------------------
	// answer: ready, error and read data, all registered in setup
	// ----------------------------------------------------------------
	always_comb begin
		next_err = 1'b0;
		if (next_sel == ebbpr_pkg::SEL_NONE) begin
			next_err = 1'b1;
		end else if (pwrite && !lanes_ok(next_sel, pstrb)) begin
			next_err = 1'b1; // R7
		end
	end

	always_comb begin
		next_rdata = ebbpr_pkg::RESET_RDATA;
		if (!pwrite) begin
			unique case (next_sel)
				ebbpr_pkg::SEL_PIN_DATA: begin
					// input pins show the pad, output pins the stored byte
					next_rdata[ebbpr_pkg::PORT_WIDTH-1:0] =
						(regs.port_pin_direction & pad_sync) |
						(~regs.port_pin_direction & regs.port_pin_data); // R2 R3 R4
				end
				ebbpr_pkg::SEL_PIN_DIRECTION: begin
					next_rdata[ebbpr_pkg::PORT_WIDTH-1:0] = regs.port_pin_direction;
				end
				ebbpr_pkg::SEL_DRIVE_CONFIG_LOW: begin
					// halfword view; a byte reader keeps only the low lane
					next_rdata[2*ebbpr_pkg::PORT_WIDTH-1:0] =
						{regs.port_drive_config_high, regs.port_drive_config_low}; // R14
				end
				ebbpr_pkg::SEL_DRIVE_CONFIG_HIGH: begin
					next_rdata[ebbpr_pkg::PORT_WIDTH-1:0] = regs.port_drive_config_high;
				end
				ebbpr_pkg::SEL_NONE: begin
					next_rdata = ebbpr_pkg::RESET_RDATA;
				end
				default: begin
					next_rdata = ebbpr_pkg::RESET_RDATA;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= next_err;
		end else begin
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= ebbpr_pkg::RESET_RDATA;
		end else if (setup_phase) begin
			prdata <= next_rdata;
		end else begin
			prdata <= ebbpr_pkg::RESET_RDATA;
		end
	end

	// ----------------------------------------------------------------
	// port registers
	// ----------------------------------------------------------------
	// data is kept while a pin is an input, so it appears once the pin turns output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs.port_pin_data <= ebbpr_pkg::RESET_PORT_REG; // R8
		end else if (wr_fire && acc_sel == ebbpr_pkg::SEL_PIN_DATA) begin
			regs.port_pin_data <= pwdata[ebbpr_pkg::PORT_WIDTH-1:0]; // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs.port_pin_direction <= ebbpr_pkg::RESET_PORT_REG; // R5 R8
		end else if (wr_fire && acc_sel == ebbpr_pkg::SEL_PIN_DIRECTION) begin
			regs.port_pin_direction <= pwdata[ebbpr_pkg::PORT_WIDTH-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs.port_drive_config_low <= ebbpr_pkg::RESET_PORT_REG; // R8
		end else if (wr_fire && acc_sel == ebbpr_pkg::SEL_DRIVE_CONFIG_LOW) begin
			regs.port_drive_config_low <= pwdata[ebbpr_pkg::PORT_WIDTH-1:0]; // R14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs.port_drive_config_high <= ebbpr_pkg::RESET_PORT_REG; // R8
		end else if (wr_fire && acc_sel == ebbpr_pkg::SEL_DRIVE_CONFIG_HIGH) begin
			regs.port_drive_config_high <= pwdata[ebbpr_pkg::PORT_WIDTH-1:0];
		end else if (wr_fire && acc_sel == ebbpr_pkg::SEL_DRIVE_CONFIG_LOW &&
			pstrb[ebbpr_pkg::HIGH_LANE]) begin
			regs.port_drive_config_high <= pwdata[2*ebbpr_pkg::PORT_WIDTH-1:ebbpr_pkg::PORT_WIDTH]; // R14
		end
	end

	// ----------------------------------------------------------------
	// pad drive decode; analog use relies on software picking high-z output
	// ----------------------------------------------------------------
	ebbpr_pad_ctrl u_pad_ctrl (
		.pclk(pclk),
		.presetn(presetn),
		.regs(regs),
		.pad_ctrl(pad_ctrl)
	);

endmodule : ebbpr_port

// ### ebbpr_port_props.sv
`timescale 1ns/10ps
module ebbpr_port_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ebbpr_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [ebbpr_pkg::DATA_WIDTH-1:0] pwdata,
	input wire logic [ebbpr_pkg::STRB_WIDTH-1:0] pstrb,
	input wire logic [ebbpr_pkg::DATA_WIDTH-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [ebbpr_pkg::PORT_WIDTH-1:0] pad_in,
	input ebbpr_pkg::ebbpr_pad_t pad_ctrl
);
	// ----
	// apb and pad checks
	// ----
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup;
	logic wr_setup;
	assign setup = psel && !penable;
	assign wr_setup = setup && pwrite;
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	chk_one_cycle_answer: assert property (setup |=> s_answer)
		else $error("answer not a one-cycle pulse");
	chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_unaligned_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("unaligned access accepted");
	chk_byte_only: assert property (wr_setup && paddr == ebbpr_pkg::ADDR_PIN_DATA
		&& pstrb != ebbpr_pkg::STRB_BYTE |=> pslverr)
		else $error("wide data write accepted");
	chk_half_accepted: assert property (wr_setup && paddr == ebbpr_pkg::ADDR_DRIVE_CONFIG_LOW
		&& pstrb == ebbpr_pkg::STRB_HALF |=> !pslverr)
		else $error("halfword config write refused");
	chk_data_upper_zero: assert property (setup && !pwrite
		&& paddr == ebbpr_pkg::ADDR_PIN_DATA |=> prdata[31:8] == 24'h0)
		else $error("data read upper bits set");
	chk_pull_exclusive: assert property ((pad_ctrl.pull_up_en & pad_ctrl.pull_down_en) == 8'h00)
		else $error("both pulls on");
	chk_pull_no_drive: assert property (((pad_ctrl.pull_up_en | pad_ctrl.pull_down_en)
		& ~pad_ctrl.oe_n) == 8'h00)
		else $error("pull on a driven pin");
	chk_pad_after_write: assert property ($changed(pad_ctrl) |-> $past(pready && pwrite, 2))
		else $error("pad change without a write");
endmodule : ebbpr_port_props

bind ebbpr_port ebbpr_port_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
	.pad_ctrl(pad_ctrl));

// ### eight_bit_bidir_port_regs_test.sv
`timescale 1ns/10ps
module eight_bit_bidir_port_regs_test;
	// ----
	// bench
	// ----
	localparam logic [19:0] AD = ebbpr_pkg::ADDR_PIN_DATA;
	localparam logic [19:0] AR = ebbpr_pkg::ADDR_PIN_DIRECTION;
	localparam logic [19:0] AL = ebbpr_pkg::ADDR_DRIVE_CONFIG_LOW;
	localparam logic [19:0] AH = ebbpr_pkg::ADDR_DRIVE_CONFIG_HIGH;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [19:0] paddr = 20'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pad_in;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	ebbpr_pkg::ebbpr_pad_t pad_ctrl;
	int num_errors = 0;
	int n_compared = 0;

	initial begin
		forever #2 pclk = ~pclk;
	end

	ebbpr_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_ctrl(pad_ctrl));
	ebbpr_pin_model pins (.pclk(pclk), .pad_ctrl(pad_ctrl), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in));

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : compare

	// request held until pready is sampled high at a rising edge; released by the next call
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] exp, input logic exp_err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? s : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 16) begin
			num_errors++;
			conclude();
		end else begin
			if (!w) compare("read data", exp, prdata);
			compare("error flag", {31'h0, exp_err}, {31'h0, pslverr});
		end
	endtask : xfer

	task automatic idle(input int k);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (k) @(posedge pclk);
	endtask : idle

	// out is only judged where the pin is driven; elsewhere it carries no meaning
	task automatic pad_chk(input logic [7:0] d, input logic [7:0] dir, input logic [7:0] lo,
		input logic [7:0] hi);
		ebbpr_pkg::ebbpr_pad_t p;
		p = {8'h00, 8'hFF, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			case ({dir[i], hi[i], lo[i]})
				3'b001: begin
					p.out[i] = 1'b1;
					p.oe_n[i] = ~d[i];
				end
				3'b010: p.oe_n[i] = d[i];
				3'b011: begin
					p.out[i] = d[i];
					p.oe_n[i] = 1'b0;
				end
				3'b101: p.pull_down_en[i] = 1'b1;
				3'b110: p.pull_up_en[i] = 1'b1;
				default: ;
			endcase
		end
		compare("pad control", {p.out & ~p.oe_n, p[23:0]},
			{pad_ctrl.out & ~p.oe_n, pad_ctrl[23:0]});
	endtask : pad_chk

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		pad_chk(8'h00, 8'h00, 8'h00, 8'h00);
		xfer(1'b0, AD, 32'h0, 4'h0, 32'h0, 1'b0);
		xfer(1'b0, AR, 32'h0, 4'h0, 32'h0, 1'b0);
		xfer(1'b0, AL, 32'h0, 4'h0, 32'h0, 1'b0);
		xfer(1'b0, AH, 32'h0, 4'h0, 32'h0, 1'b0);
		xfer(1'b1, AD, 32'hA5, 4'h1, 32'h0, 1'b0);
		xfer(1'b1, AL, 32'hFFFF, 4'h3, 32'h0, 1'b0);
		idle(4);
		pad_chk(8'hA5, 8'h00, 8'hFF, 8'hFF);
		xfer(1'b0, AD, 32'h0, 4'h0, 32'hA5, 1'b0);
		xfer(1'b0, AL, 32'h0, 4'h0, 32'hFFFF, 1'b0);
		xfer(1'b0, AH, 32'h0, 4'h0, 32'hFF, 1'b0);
		xfer(1'b1, AD, 32'h11, 4'h3, 32'h0, 1'b1);
		xfer(1'b1, AR, 32'h11, 4'h3, 32'h0, 1'b1);
		xfer(1'b1, AH, 32'h11, 4'h3, 32'h0, 1'b1);
		xfer(1'b0, AH + 20'h4, 32'h0, 4'h0, 32'h0, 1'b1);
		xfer(1'b0, AD + 20'h1, 32'h0, 4'h0, 32'h0, 1'b1);
		xfer(1'b0, AD, 32'h0, 4'h0, 32'hA5, 1'b0);
		xfer(1'b1, AD, 32'h5A, 4'h1, 32'h0, 1'b0);
		xfer(1'b1, AR, 32'hF0, 4'h1, 32'h0, 1'b0);
		xfer(1'b1, AL, 32'hAA, 4'h1, 32'h0, 1'b0);
		xfer(1'b1, AH, 32'hCC, 4'h1, 32'h0, 1'b0);
		ext_en <= 8'h90;
		ext_val <= 8'h80;
		idle(6);
		pad_chk(8'h5A, 8'hF0, 8'hAA, 8'hCC);
		xfer(1'b0, AD, 32'h0, 4'h0, 32'hCA, 1'b0);
		xfer(1'b1, AR, 32'hE0, 4'h1, 32'h0, 1'b0);
		idle(4);
		pad_chk(8'h5A, 8'hE0, 8'hAA, 8'hCC);
		xfer(1'b0, AD, 32'h0, 4'h0, 32'hDA, 1'b0);
		xfer(1'b1, AD, 32'hA5, 4'h1, 32'h0, 1'b0);
		idle(4);
		pad_chk(8'hA5, 8'hE0, 8'hAA, 8'hCC);
		xfer(1'b1, AR, 32'h00, 4'h1, 32'h0, 1'b0);
		xfer(1'b1, AL, 32'h0000, 4'h3, 32'h0, 1'b0);
		idle(4);
		pad_chk(8'hA5, 8'h00, 8'h00, 8'h00);
		xfer(1'b0, AD, 32'h0, 4'h0, 32'hA5, 1'b0);
		idle(1);
		conclude();
	end
endmodule : eight_bit_bidir_port_regs_test
